// ### logic/sdp_pkg.sv
// Package of constants and carrier types for the stride data prefetcher
package sdp_pkg;

  // ==========================================================================
  // Geometry
  localparam int ADDR_W      = 40;
  localparam int LINE_SHIFT  = 6;   // 64-byte lines
  localparam int PAGE_SHIFT  = 12;  // 4-KByte pages
  localparam int LINE_W      = ADDR_W - LINE_SHIFT;
  localparam int IN_PAGE_W   = PAGE_SHIFT - LINE_SHIFT;
  localparam int PAGE_W      = ADDR_W - PAGE_SHIFT;

  // ==========================================================================
  // Defaults for tunable parameters
  localparam int DEF_TRIGGER_LINES = 4;  // Trigger threshold distance, in lines
  localparam int DEF_AHEAD_LINES   = 2;  // Look-ahead depth, in lines
  localparam int DEF_MIN_MISSES    = 2;  // Misses needed before prefetching

  // ==========================================================================
  // Software hint levels
  typedef enum logic [1:0] {
    SDP_HINT_NTA = 2'h0,
    SDP_HINT_L1  = 2'h1,
    SDP_HINT_L2  = 2'h2,
    SDP_HINT_L3  = 2'h3
  } sdp_hint_t;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
  } sdp_miss_t;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    sdp_hint_t         hint;
    logic              l1_hit;
  } sdp_swpf_t;

  typedef struct packed {
    logic              valid;
    logic [LINE_W-1:0] line;
    logic              from_sw;
    sdp_hint_t         hint;
  } sdp_req_t;

endpackage : sdp_pkg

// ### logic/sdp_stride_calc.sv
// Stride and page arithmetic between two line addresses
`timescale 1ns/1ns
module sdp_stride_calc #(
  parameter int TRIGGER_LINES = sdp_pkg::DEF_TRIGGER_LINES
) (
  input  wire logic [sdp_pkg::LINE_W-1:0] prev_line_i,
  input  wire logic [sdp_pkg::LINE_W-1:0] cur_line_i,
  output logic                            same_page_o,
  output logic                            near_o,
  output logic                            up_o
);
  logic [sdp_pkg::LINE_W-1:0] diff;
  logic [sdp_pkg::LINE_W-1:0] mag;

  always_comb begin
    diff        = cur_line_i - prev_line_i;
    up_o        = ~diff[sdp_pkg::LINE_W-1];
    mag         = up_o ? diff : (prev_line_i - cur_line_i);
    near_o      = (mag != '0) && (mag < sdp_pkg::LINE_W'(TRIGGER_LINES));
    same_page_o = cur_line_i[sdp_pkg::LINE_W-1:sdp_pkg::IN_PAGE_W]
               == prev_line_i[sdp_pkg::LINE_W-1:sdp_pkg::IN_PAGE_W];
  end
endmodule : sdp_stride_calc

// ### logic/sdp_prefetcher.sv
// Stride data prefetcher: hardware stream engine plus software hint path
//
// Summary of operation
// - Miss history drives fills into last-level cache
// - Keep fetches two lines ahead of stream
// - Track only while miss stride below threshold
// - No stream prefetch before more than one miss
// - Stream never prefetches outside the current 4-KByte page
// - New page needs demand misses before stream prefetching
// - Stream runs on past data structure ends
// - Four software hint levels, one line each
// - Hints for lines in L1 are dropped
// - Everything works on 64-byte lines
//
// Interfaces
// miss_i          one-cycle pulse per demand data miss, byte address
// swpf_i          software hint, held by the core until swpf_ready_o
// swpf_ready_o    high while the request slot can take a hint
// req_o           prefetch request, held until req_ready_i is high at an edge
// active_o        a trained stream is prefetching
// swpf_dropped_o  one-cycle pulse for a hint that already hit in L1
//
// Timing
// A hint accepted at an edge shows on req_o one cycle later.
// The first near miss on a stream, its second miss, trains it; the first stream
// request follows in the next cycle without a miss or a hint.
// Each stream miss frees one look-ahead slot; a slot is refilled
// one line past the last request, in the stream direction.
//
// Reset
// Synchronous and active high; the request slot and the drop flag
// clear and the stream engine restarts untrained.
//
// Limitations
// One stream is tracked; a far miss or a new page retrains it.
// Stream requests step one line at a time whatever the miss stride.
// A stream that reaches a page end stays quiet until a near miss in
// the same page resumes it or two misses in the next page retrain
// it, so the next page is never guessed.
// Hints for lines already in L1 are discarded, never queued, but such a
// hint still waits on swpf_ready_o behind an outstanding request.
// Nothing marks the end of a data structure, so a stream runs on
// past its last element until misses stop freeing slots.
`timescale 1ns/1ns
module sdp_prefetcher #(
  parameter int TRIGGER_LINES = sdp_pkg::DEF_TRIGGER_LINES,
  parameter int AHEAD_LINES   = sdp_pkg::DEF_AHEAD_LINES,
  parameter int MIN_MISSES    = sdp_pkg::DEF_MIN_MISSES
) (
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  input  wire sdp_pkg::sdp_miss_t miss_i,
  input  wire sdp_pkg::sdp_swpf_t swpf_i,
  output logic                   swpf_ready_o,
  output sdp_pkg::sdp_req_t      req_o,
  input  wire logic              req_ready_i,
  output logic                   active_o,
  output logic                   swpf_dropped_o
);

  // ==========================================================================
  // Local constants
  localparam int               CNT_W     = 4;  // Miss and look-ahead counter width
  localparam logic [CNT_W-1:0] CNT_ZERO  = '0;
  localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);
  localparam logic [CNT_W-1:0] MIN_CNT   = CNT_W'(MIN_MISSES);
  localparam logic [CNT_W-1:0] AHEAD_CNT = CNT_W'(AHEAD_LINES);

  // ==========================================================================
  // State
  typedef enum logic [1:0] {SDP_IDLE, SDP_TRAIN, SDP_STREAM, SDP_HOLD} sdp_mode_t;

  typedef struct packed {
    sdp_mode_t                  mode;
    logic [sdp_pkg::LINE_W-1:0] last_miss;
    logic [sdp_pkg::LINE_W-1:0] next_pf;
    logic                       up;
    logic [CNT_W-1:0]           misses;
    logic [CNT_W-1:0]           ahead;
    sdp_pkg::sdp_req_t          req;
    logic                       dropped;
  } sdp_state_t;

  sdp_state_t st;
  sdp_state_t next_st;

  logic [sdp_pkg::LINE_W-1:0] miss_line;
  logic                       same_page;
  logic                       near;
  logic                       up;

  // ==========================================================================
  // Helpers
  function automatic logic [sdp_pkg::LINE_W-1:0] to_line(
    input logic [sdp_pkg::ADDR_W-1:0] a
  );
    return a[sdp_pkg::ADDR_W-1:sdp_pkg::LINE_SHIFT];
  endfunction : to_line

  function automatic logic [sdp_pkg::LINE_W-1:0] step(
    input logic [sdp_pkg::LINE_W-1:0] l,
    input logic                       go_up
  );
    return go_up ? l + 1'b1 : l - 1'b1;
  endfunction : step

  function automatic logic [sdp_pkg::PAGE_W-1:0] page_of(
    input logic [sdp_pkg::LINE_W-1:0] l
  );
    return l[sdp_pkg::LINE_W-1:sdp_pkg::IN_PAGE_W];
  endfunction : page_of

  // ==========================================================================
  // Miss decode
  assign miss_line = to_line(miss_i.addr);

  sdp_stride_calc #(
    .TRIGGER_LINES (TRIGGER_LINES)
  ) u_calc (
    .prev_line_i (st.last_miss),
    .cur_line_i  (miss_line),
    .same_page_o (same_page),
    .near_o      (near),
    .up_o        (up)
  );

  // ==========================================================================
  // Next state
  logic                       out_free;
  logic [sdp_pkg::LINE_W-1:0] cand;
  logic                       cand_in_page;
  logic                       take_hint;
  logic                       stream_slot;
  logic                       trained;

  always_comb begin
    next_st         = st;
    next_st.dropped = 1'b0;
    out_free        = !st.req.valid || req_ready_i;
    take_hint       = swpf_i.valid && out_free;
    trained         = (st.misses + CNT_ONE) >= MIN_CNT;
    if (st.req.valid && req_ready_i) begin
      next_st.req.valid = 1'b0;
    end
    cand         = st.next_pf;
    cand_in_page = page_of(cand) == page_of(st.last_miss);
    // The stream only issues in a cycle without a miss or a hint
    stream_slot  = (st.mode == SDP_STREAM) && !miss_i.valid && out_free
                && (st.ahead < AHEAD_CNT);

    // Demand miss training
    if (miss_i.valid) begin
      next_st.last_miss = miss_line;
      if (st.mode == SDP_IDLE || !near) begin
        next_st.mode   = SDP_TRAIN;
        next_st.misses = CNT_ONE;
        next_st.ahead  = CNT_ZERO;
      end else if (!same_page) begin
        // The next page is never guessed; its own misses retrain the stream
        next_st.mode   = SDP_TRAIN;
        next_st.misses = CNT_ONE;
        next_st.ahead  = CNT_ZERO;
        next_st.up     = up;
      end else begin
        next_st.up = up;
        if (st.misses < MIN_CNT) begin
          next_st.misses = st.misses + CNT_ONE;
        end
        if (trained) begin
          next_st.mode = SDP_STREAM;
          if (st.mode != SDP_STREAM || up != st.up) begin
            // Fresh stream or a turn: restart the look-ahead at the miss
            next_st.next_pf = step(miss_line, up);
            next_st.ahead   = CNT_ZERO;
          end else if (st.ahead != CNT_ZERO) begin
            // Each demand miss on the stream frees one look-ahead slot
            next_st.ahead = st.ahead - CNT_ONE;
          end
        end
      end
    end

    // Request issue: software hints win over the stream
    swpf_ready_o = out_free;
    if (take_hint) begin
      if (swpf_i.l1_hit) begin
        next_st.dropped = 1'b1;
      end else begin
        next_st.req.valid   = 1'b1;
        next_st.req.line    = to_line(swpf_i.addr);
        next_st.req.from_sw = 1'b1;
        next_st.req.hint    = swpf_i.hint;
      end
    end else if (stream_slot) begin
      if (cand_in_page) begin
        next_st.req.valid   = 1'b1;
        next_st.req.line    = cand;
        next_st.req.from_sw = 1'b0;
        next_st.req.hint    = sdp_pkg::SDP_HINT_L3;
        next_st.next_pf     = step(cand, st.up);
        next_st.ahead       = st.ahead + CNT_ONE;
      end else begin
        // Page end: stay quiet until a near miss in this page or misses in the next page
        next_st.mode = SDP_HOLD;
      end
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  assign req_o          = st.req;
  assign active_o       = (st.mode == SDP_STREAM);
  assign swpf_dropped_o = st.dropped;

endmodule : sdp_prefetcher

// ### testbench/sdp_prefetcher_assertions.sv
// Port checker of the stride data prefetcher
`timescale 1ns/1ns
module sdp_prefetcher_chk #(
  parameter int TRIGGER_LINES = 4,
  parameter int AHEAD_LINES   = 2,
  parameter int MIN_MISSES    = 2
) (
  input wire logic               clk_sys_i,
  input wire logic               sys_rst_i,
  input wire sdp_pkg::sdp_miss_t miss_i,
  input wire sdp_pkg::sdp_swpf_t swpf_i,
  input wire logic               swpf_ready_o,
  input wire sdp_pkg::sdp_req_t  req_o,
  input wire logic               req_ready_i,
  input wire logic               active_o,
  input wire logic               swpf_dropped_o
);
  // ====
  // Last miss line, miss count and first cycle of each stream request
  logic [sdp_pkg::LINE_W-1:0]        last;
  logic [sdp_pkg::LINE_W-1:0]        mline;
  logic signed [sdp_pkg::LINE_W-1:0] dl;
  logic signed [sdp_pkg::LINE_W-1:0] md;
  logic                              held;
  logic                              newst;
  logic                              close;
  int                                cnt;
  assign newst = req_o.valid && !req_o.from_sw && !held;
  assign dl    = req_o.line - last;
  assign mline = miss_i.addr[sdp_pkg::ADDR_W-1:sdp_pkg::LINE_SHIFT];
  assign md    = mline - last;
  // A miss continues the stream only if near and in the same page
  assign close = md != 0 && md < TRIGGER_LINES && md > -TRIGGER_LINES
              && mline[sdp_pkg::LINE_W-1:sdp_pkg::IN_PAGE_W]
              == last[sdp_pkg::LINE_W-1:sdp_pkg::IN_PAGE_W];
  always_ff @(posedge clk_sys_i) begin
    held <= !sys_rst_i && req_o.valid && !req_ready_i;
    if (sys_rst_i) begin
      cnt  <= 0;
      last <= '0;
    end else if (miss_i.valid) begin
      last <= mline;
      if (!close) begin
        cnt <= 1;
      end else if (cnt < MIN_MISSES) begin
        cnt <= cnt + 1;
      end
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  AST_REQ_STANDS: assert property (
    req_o.valid && !req_ready_i |=> req_o.valid && $stable(req_o)) else $error("req moved");
  AST_SW_REQ: assert property (
    swpf_i.valid && swpf_ready_o && !swpf_i.l1_hit |=> req_o.valid && req_o.from_sw
    && req_o.hint == $past(swpf_i.hint)
    && req_o.line == ($past(swpf_i.addr) >> sdp_pkg::LINE_SHIFT))
    else $error("bad hint req");
  AST_SW_DROP: assert property (
    swpf_i.valid && swpf_ready_o && swpf_i.l1_hit |=> swpf_dropped_o) else $error("no drop");
  AST_SW_READY: assert property (
    swpf_ready_o == (!req_o.valid || req_ready_i)) else $error("bad ready");
  AST_STREAM_LLC: assert property (
    newst |-> req_o.hint == sdp_pkg::SDP_HINT_L3) else $error("bad level");
  AST_TRAINED: assert property (
    newst |-> cnt >= MIN_MISSES) else $error("untrained");
  AST_SAME_PAGE: assert property (
    newst |-> req_o.line[sdp_pkg::LINE_W-1:sdp_pkg::IN_PAGE_W]
    == last[sdp_pkg::LINE_W-1:sdp_pkg::IN_PAGE_W]) else $error("page crossed");
  AST_STREAM_ACTIVE: assert property (
    newst |-> active_o) else $error("stream request while inactive");
  AST_AHEAD: assert property (
    newst |-> dl != 0 && dl <= AHEAD_LINES && dl >= -AHEAD_LINES) else $error("too far");
  cover property (newst);
  cover property (swpf_dropped_o);
  cover property (req_o.valid && !req_ready_i);
endmodule : sdp_prefetcher_chk
bind sdp_prefetcher sdp_prefetcher_chk #(.TRIGGER_LINES(TRIGGER_LINES),
  .AHEAD_LINES(AHEAD_LINES), .MIN_MISSES(MIN_MISSES)) chk_i (.clk_sys_i(clk_sys_i),
  .sys_rst_i(sys_rst_i), .miss_i(miss_i), .swpf_i(swpf_i), .swpf_ready_o(swpf_ready_o),
  .req_o(req_o), .req_ready_i(req_ready_i), .active_o(active_o),
  .swpf_dropped_o(swpf_dropped_o));

// ### testbench/sdp_llc_model.sv
// Last-level cache model taking prefetch requests promptly or with stalls
`timescale 1ns/1ns
module sdp_llc_model (
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  input  wire logic slow_i,
  output logic      req_ready_o
);
  always_ff @(posedge clk_sys_i) begin
    req_ready_o <= sys_rst_i | !slow_i | 1'($urandom);
  end
endmodule : sdp_llc_model

// ### testbench/tb.sv
// Testbench of the stride data prefetcher
`timescale 1ns/1ns
module tb;
  logic               clk_sys_i = 1'h0;
  logic               sys_rst_i = 1'h1;
  logic               slow      = 1'h0;
  sdp_pkg::sdp_miss_t miss_i    = '0;
  sdp_pkg::sdp_swpf_t swpf_i    = '0;
  sdp_pkg::sdp_req_t  req_o;
  logic               swpf_ready_o, req_ready_i, active_o, swpf_dropped_o;
  logic [36:0]        q[$];
  logic [27:0]        pg;
  int                 n_mismatch = 0;
  int                 n_tests    = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  sdp_prefetcher sdp_prefetcher_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .miss_i(miss_i), .swpf_i(swpf_i), .swpf_ready_o(swpf_ready_o), .req_o(req_o),
    .req_ready_i(req_ready_i), .active_o(active_o), .swpf_dropped_o(swpf_dropped_o));
  sdp_llc_model sdp_llc_model_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .slow_i(slow), .req_ready_o(req_ready_i));
  task automatic check(input logic [36:0] seen, input logic [36:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %h %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic miss(input logic [5:0] off);
    @(posedge clk_sys_i);
    miss_i <= '{1'h1, {pg, off, 6'($urandom)}};
    @(posedge clk_sys_i);
    miss_i.valid <= 1'h0;
  endtask : miss
  // ====
  // Two unit-stride misses, then the lines expected ahead of them
  task automatic pair(input logic [5:0] off, input int n);
    for (int i = 0; i < n; i++) q.push_back({1'h0, sdp_pkg::SDP_HINT_L3, pg, 6'(off + 2 + i)});
    miss(off);
    miss(off + 6'h1);
  endtask : pair
  task automatic hint(input logic [1:0] h, input logic hit);
    logic [39:0] a;
    a = {pg, 6'($urandom), 6'h0};
    if (!hit) q.push_back({1'h1, h, a[39:6]});
    @(posedge clk_sys_i);
    swpf_i <= '{1'h1, a, sdp_pkg::sdp_hint_t'(h), hit};
    do @(negedge clk_sys_i); while (!swpf_ready_o);
    @(posedge clk_sys_i);
    swpf_i.valid <= 1'h0;
    @(negedge clk_sys_i);
    check(37'(swpf_dropped_o), 37'(hit));
  endtask : hint
  task automatic drain();
    for (int i = 0; i < 60 && q.size() != 0; i++) @(posedge clk_sys_i);
    repeat (6) @(posedge clk_sys_i);
    check(37'(q.size()), 37'h0);
  endtask : drain
  always @(posedge clk_sys_i) begin
    if (!sys_rst_i && req_o.valid && req_ready_i) begin
      if (q.size() == 0) check(37'(q.size()), 37'h1);
      else check({req_o.from_sw, req_o.hint, req_o.line}, q.pop_front());
    end
  end
  initial begin
    repeat (3000) @(posedge clk_sys_i);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'hEB1E7739));
    pg = 28'($urandom);
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'h0;
    @(negedge clk_sys_i);
    check(37'(req_o.valid), 37'h0);
    check(37'(swpf_ready_o), 37'h1);
    slow = 1'h1;
    for (int h = 0; h < 4; h++) hint(2'(h), 1'h0);
    hint(2'h2, 1'h1);
    drain();
    slow <= 1'h0;
    pair(6'h0, 2);
    drain();
    check(37'(active_o), 37'h1);
    q.push_back({1'h0, sdp_pkg::SDP_HINT_L3, pg, 6'h4});
    miss(6'h2);
    drain();
    slow <= 1'h1;
    pair(6'h3D, 1);
    drain();
    check(37'(active_o), 37'h0);
    pg = pg + 28'h1;
    pair(6'h0, 2);
    drain();
    check(37'(active_o), 37'h1);
    pg = 28'($urandom);
    miss(6'h0);
    miss(6'h4);
    drain();
    check(37'(active_o), 37'h0);
    print_verdict();
  end
endmodule : tb
